// [logic/usdp_core.sv]
// USART transmit and receive data path, top level
//
// Behaviour
// - Transmit enable hands the transmit pin to the serial output.
// - Sync mode shifts transmit data on the external clock.
// - Buffer write loads buffer; moves to shifter when idle or after stop.
// - Shifter sends a whole frame at divider, double speed or external rate.
// - Bits above the character size are ignored on transmit.
// - Buffer empty flag high while empty, cleared by an unmoved write.
// - Buffer empty interrupt is a level while enabled and empty.
// - Transmit complete sets when frame done and buffer empty.
// - Transmit complete clears on service or on writing one.
// - Transmit complete interrupt requested while enabled and set.
// - Parity bit inserted after data, before first stop bit.
// - Transmit disable waits until shifter and buffer are empty.
// - Receive enable hands the receive pin to the receiver.
// - Sync mode samples receive data on the external clock.
// - Reception starts at valid start bit; bits shifted to first stop.
// - Any second stop bit is ignored by the receiver.
// - First stop bit moves frame into the receive buffer.
// - Read data has unused upper bits as zeros.
// - Receive complete flag shows unread data; disable flushes it.
// - Frame: low start, data LSB first, parity, high stops, idle high.
// - Even parity is xor of data; odd is its inverse.
`timescale 1ns/100ps
`default_nettype none
module usdp_core #(
  parameter int DIV_W = 12
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [DIV_W-1:0] baud_div_i,
  input  wire logic             double_speed_bit_i,
  input  wire logic             sync_mode_i,
  input  wire logic             sample_rise_i,
  input  wire logic [2:0]       char_size_field_i,
  input  wire logic [1:0]       parity_mode_i,
  input  wire logic             two_stop_i,
  input  wire logic             tx_enable_bit_i,
  input  wire logic             rx_enable_bit_i,
  input  wire logic             buffer_empty_irq_en_i,
  input  wire logic             tx_complete_irq_en_i,
  input  wire logic             tx_ninth_bit_i,
  input  wire logic             data_wr_i,
  input  wire logic [7:0]       data_wdata_i,
  input  wire logic             data_rd_i,
  input  wire logic             tx_done_clr_i,
  input  wire logic             tx_done_ack_i,
  input  wire logic             ext_serial_clock_i,
  input  wire logic             rxd_pin_i,
  input  wire logic             port_tx_i,
  output logic                  txd_o,
  output logic                  tx_active_o,
  output logic                  rx_active_o,
  output logic                  buffer_empty_flag_o,
  output logic                  tx_complete_flag_o,
  output logic                  rx_complete_flag_o,
  output logic [7:0]            data_rdata_o,
  output logic                  rx_ninth_bit_o,
  output logic                  buffer_empty_irq_o,
  output logic                  tx_complete_irq_o
);
  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  logic os_tick, ext_rise, ext_fall;
  logic tx_tick, rx_tick, rx_os, par_tx, par_rx;
  logic [3:0] ovs_last, ovs_mid;

  usdp_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .baud_div_i  (baud_div_i),
    .sync_mode_i (sync_mode_i),
    .ext_clk_i   (ext_serial_clock_i),
    .os_tick_o   (os_tick),
    .ext_rise_o  (ext_rise),
    .ext_fall_o  (ext_fall)
  );

  // Async bits use oversampling; sync change and sample opposite edges
  assign ovs_last = double_speed_bit_i ? usdp_pkg::OVS_DOUBLE_LAST
                                       : usdp_pkg::OVS_NORMAL_LAST;
  assign ovs_mid  = double_speed_bit_i ? usdp_pkg::OVS_DOUBLE_MID
                                       : usdp_pkg::OVS_NORMAL_MID;
  assign rx_os    = sync_mode_i ? (sample_rise_i ? ext_rise : ext_fall)
                                : os_tick;

  // ----------------------------------------------------------------
  // Transmitter state
  // ----------------------------------------------------------------
  usdp_pkg::usdp_state_t tx_st_reg, tx_st_next;
  logic [8:0] tbuf_reg,  tbuf_next;
  logic       tfull_reg, tfull_next;
  logic [8:0] tsh_reg,   tsh_next;
  logic [3:0] tx_ovs_reg, tx_ovs_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic       tx_line_reg, tx_line_next;
  logic       tx_own_reg,  tx_own_next;
  logic       txc_reg,     txc_next;
  logic [3:0] nbits;
  logic [8:0] wr_word;

  assign tx_tick  = sync_mode_i ? (sample_rise_i ? ext_fall : ext_rise)
                                : (os_tick && tx_ovs_reg == ovs_last);
  always_comb begin
    unique case (char_size_field_i)
      usdp_pkg::CSZ_5: nbits = 4'h5;
      usdp_pkg::CSZ_6: nbits = 4'h6;
      usdp_pkg::CSZ_7: nbits = 4'h7;
      usdp_pkg::CSZ_9: nbits = 4'h9;
      default:         nbits = 4'h8;
    endcase
  end

  // Ninth bit is captured with the low byte, so it must be set first
  assign wr_word = {tx_ninth_bit_i, data_wdata_i};

  usdp_parity u_ptx (
    .data_i   (tsh_reg),
    .size_i   (char_size_field_i),
    .odd_i    (parity_mode_i[0]),
    .parity_o (par_tx)
  );

  // Transmit next state; a frame in flight always completes
  always_comb begin
    logic frame_end;
    frame_end   = 1'b0;
    tx_st_next  = tx_st_reg;
    tbuf_next   = tbuf_reg;
    tfull_next  = tfull_reg;
    tsh_next    = tsh_reg;
    tx_bit_next = tx_bit_reg;
    tx_line_next = tx_line_reg;
    txc_next    = txc_reg;
    tx_ovs_next = tx_ovs_reg;
    if (os_tick)
      tx_ovs_next = (tx_ovs_reg == ovs_last) ? 4'h0 : tx_ovs_reg + 4'h1;
    if (data_wr_i && tx_enable_bit_i) begin
      tbuf_next  = wr_word;
      tfull_next = 1'b1;
    end
    if (tx_tick) begin
      unique case (tx_st_reg)
        usdp_pkg::USDP_IDLE: tx_line_next = usdp_pkg::LINE_IDLE;
        usdp_pkg::USDP_START: begin
          tx_line_next = tsh_reg[0];
          tx_bit_next  = 4'h1;
          tx_st_next   = usdp_pkg::USDP_DATA;
        end
        usdp_pkg::USDP_DATA: begin
          if (tx_bit_reg == nbits) begin
            tx_line_next = parity_mode_i[1] ? par_tx : 1'b1;
            tx_st_next   = parity_mode_i[1] ? usdp_pkg::USDP_PARITY
                                            : usdp_pkg::USDP_STOP1;
          end else begin
            // Word kept whole so parity still sees every data bit
            tx_line_next = tsh_reg[tx_bit_reg];
            tx_bit_next  = tx_bit_reg + 4'h1;
          end
        end
        usdp_pkg::USDP_PARITY: begin
          tx_line_next = 1'b1;
          tx_st_next   = usdp_pkg::USDP_STOP1;
        end
        usdp_pkg::USDP_STOP1: begin
          if (two_stop_i)
            tx_st_next = usdp_pkg::USDP_STOP2;
          else
            frame_end = 1'b1;
        end
        default: frame_end = 1'b1;
      endcase
      // Load from buffer when idle or right after last stop bit
      if ((frame_end || tx_st_reg == usdp_pkg::USDP_IDLE) && tfull_reg) begin
        tsh_next     = tbuf_reg;
        tfull_next   = data_wr_i && tx_enable_bit_i;
        tx_line_next = 1'b0;
        tx_st_next   = usdp_pkg::USDP_START;
      end else if (frame_end) begin
        tx_st_next = usdp_pkg::USDP_IDLE;
        txc_next   = 1'b1;
      end
    end
    // Set wins over a same-cycle clear
    if ((tx_done_clr_i || tx_done_ack_i) && !(tx_tick && frame_end &&
        !tfull_reg))
      txc_next = 1'b0;
    // Pin stays owned until shifter and buffer are both empty
    tx_own_next = tx_enable_bit_i ||
                  (tx_own_reg && (tfull_next ||
                   tx_st_next != usdp_pkg::USDP_IDLE));
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      tx_st_reg   <= usdp_pkg::USDP_IDLE;
      tbuf_reg    <= 9'h000;
      tfull_reg   <= ~usdp_pkg::BUF_EMPTY_RST;
      tsh_reg     <= 9'h000;
      tx_ovs_reg  <= 4'h0;
      tx_bit_reg  <= 4'h0;
      tx_line_reg <= usdp_pkg::LINE_IDLE;
      tx_own_reg  <= 1'b0;
      txc_reg     <= usdp_pkg::TX_DONE_RST;
    end else begin
      tx_st_reg   <= tx_st_next;
      tbuf_reg    <= tbuf_next;
      tfull_reg   <= tfull_next;
      tsh_reg     <= tsh_next;
      tx_ovs_reg  <= tx_ovs_next;
      tx_bit_reg  <= tx_bit_next;
      tx_line_reg <= tx_line_next;
      tx_own_reg  <= tx_own_next;
      txc_reg     <= txc_next;
    end
  end

  // ----------------------------------------------------------------
  // Receiver state
  // ----------------------------------------------------------------
  usdp_pkg::usdp_state_t rx_st_reg, rx_st_next;
  logic [8:0] rsh_reg,  rsh_next;
  logic [8:0] rbuf_reg, rbuf_next;
  logic       rxc_reg,  rxc_next;
  logic [3:0] rx_ovs_reg, rx_ovs_next;
  logic [3:0] rx_bit_reg, rx_bit_next;

  usdp_parity u_prx (
    .data_i   (rsh_reg),
    .size_i   (char_size_field_i),
    .odd_i    (parity_mode_i[0]),
    .parity_o (par_rx)
  );

  // Sample point is bit middle in async mode, every selected external edge in sync mode
  assign rx_tick = sync_mode_i ? rx_os : (rx_os && rx_ovs_reg == ovs_mid);

  // Receive next state; disable is immediate and flushes the buffer
  always_comb begin
    logic [8:0] aligned;
    aligned     = rsh_reg >> (4'h9 - nbits);
    rx_st_next  = rx_st_reg;
    rsh_next    = rsh_reg;
    rbuf_next   = rbuf_reg;
    rx_bit_next = rx_bit_reg;
    rx_ovs_next = rx_os ? ((rx_ovs_reg == ovs_last) ? 4'h0
                                                    : rx_ovs_reg + 4'h1)
                        : rx_ovs_reg;
    rxc_next    = rxc_reg && !data_rd_i;
    unique case (rx_st_reg)
      usdp_pkg::USDP_IDLE: begin
        rx_ovs_next = 4'h0;
        if (rx_os && !rxd_pin_i)
          rx_st_next = usdp_pkg::USDP_START;
      end
      usdp_pkg::USDP_START: begin
        if (rx_tick) begin
          // A high level at mid start is a glitch, not a start bit
          rx_st_next  = rxd_pin_i ? usdp_pkg::USDP_IDLE
                                  : usdp_pkg::USDP_DATA;
          rx_bit_next = 4'h0;
        end
      end
      usdp_pkg::USDP_DATA: begin
        if (rx_tick) begin
          rsh_next    = {rxd_pin_i, rsh_reg[8:1]};
          rx_bit_next = rx_bit_reg + 4'h1;
          if (rx_bit_reg + 4'h1 == nbits)
            rx_st_next = parity_mode_i[1] ? usdp_pkg::USDP_PARITY
                                          : usdp_pkg::USDP_STOP1;
        end
      end
      usdp_pkg::USDP_PARITY: begin
        if (rx_tick)
          rx_st_next = usdp_pkg::USDP_STOP1;
      end
      default: begin
        // Only the first stop bit is looked at
        if (rx_tick) begin
          rbuf_next  = aligned;
          rxc_next   = 1'b1;
          rx_st_next = usdp_pkg::USDP_IDLE;
        end
      end
    endcase
    if (!rx_enable_bit_i) begin
      rx_st_next = usdp_pkg::USDP_IDLE;
      rxc_next   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rx_st_reg  <= usdp_pkg::USDP_IDLE;
      rsh_reg    <= 9'h000;
      rbuf_reg   <= 9'h000;
      rxc_reg    <= 1'b0;
      rx_ovs_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
    end else begin
      rx_st_reg  <= rx_st_next;
      rsh_reg    <= rsh_next;
      rbuf_reg   <= rbuf_next;
      rxc_reg    <= rxc_next;
      rx_ovs_reg <= rx_ovs_next;
      rx_bit_reg <= rx_bit_next;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Pin mux and flags registered so every output leaves a flip-flop
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      txd_o               <= usdp_pkg::LINE_IDLE;
      tx_active_o         <= 1'b0;
      rx_active_o         <= 1'b0;
      buffer_empty_flag_o <= usdp_pkg::BUF_EMPTY_RST;
      tx_complete_flag_o  <= usdp_pkg::TX_DONE_RST;
      rx_complete_flag_o  <= 1'b0;
      data_rdata_o        <= 8'h00;
      rx_ninth_bit_o      <= 1'b0;
      buffer_empty_irq_o  <= 1'b0;
      tx_complete_irq_o   <= 1'b0;
    end else begin
      txd_o               <= tx_own_next ? tx_line_next : port_tx_i;
      tx_active_o         <= tx_own_next;
      rx_active_o         <= rx_enable_bit_i;
      buffer_empty_flag_o <= ~tfull_next;
      tx_complete_flag_o  <= txc_next;
      rx_complete_flag_o  <= rxc_next;
      data_rdata_o        <= rbuf_next[7:0];
      rx_ninth_bit_o      <= rbuf_next[8];
      buffer_empty_irq_o  <= buffer_empty_irq_en_i & ~tfull_next;
      tx_complete_irq_o   <= tx_complete_irq_en_i & txc_next;
    end
  end
endmodule
`default_nettype wire

// [logic/usdp_pkg.sv]
// Package: constants and types for the USART transmit and receive data path
package usdp_pkg;
  // ----------------------------------------------------------------
  // Character size codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CSZ_5 = 3'h0;
  localparam logic [2:0] CSZ_6 = 3'h1;
  localparam logic [2:0] CSZ_7 = 3'h2;
  localparam logic [2:0] CSZ_8 = 3'h3;
  localparam logic [2:0] CSZ_9 = 3'h7;
  // ----------------------------------------------------------------
  // Oversampling counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OVS_NORMAL_LAST = 4'hF;  // 16 samples per bit
  localparam logic [3:0] OVS_DOUBLE_LAST = 4'h7;  // 8 samples per bit
  localparam logic [3:0] OVS_NORMAL_MID  = 4'h7;
  localparam logic [3:0] OVS_DOUBLE_MID  = 4'h3;
  localparam logic [11:0] BAUD_DIV_RST   = 12'h000;
  localparam logic       BUF_EMPTY_RST   = 1'b1;
  localparam logic       TX_DONE_RST     = 1'b0;
  localparam logic       LINE_IDLE       = 1'b1;
  // ----------------------------------------------------------------
  // Shared state encoding of both shifters
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    USDP_IDLE   = 3'h0,
    USDP_START  = 3'h1,
    USDP_DATA   = 3'h2,
    USDP_PARITY = 3'h3,
    USDP_STOP1  = 3'h4,
    USDP_STOP2  = 3'h5
  } usdp_state_t;
endpackage

// [logic/usdp_tick_gen.sv]
// Bit rate tick generator: baud divider or external clock edge detect
`timescale 1ns/100ps
`default_nettype none
module usdp_tick_gen #(
  parameter int DIV_W = 12
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [DIV_W-1:0] baud_div_i,
  input  wire logic             sync_mode_i,
  input  wire logic             ext_clk_i,
  output logic                  os_tick_o,
  output logic                  ext_rise_o,
  output logic                  ext_fall_o
);
  logic [DIV_W-1:0] cnt_reg,  cnt_next;
  logic             s1_reg,   s2_reg,  s3_reg;
  logic             os_next,  rise_next, fall_next;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // Two-flop synchroniser, edge taken from stages two and three only
  always_comb begin
    os_next   = 1'b0;
    cnt_next  = cnt_reg - {{(DIV_W-1){1'b0}}, 1'b1};
    if (cnt_reg == '0) begin
      cnt_next = baud_div_i;
      os_next  = 1'b1;
    end
    rise_next = sync_mode_i & s2_reg & ~s3_reg;
    fall_next = sync_mode_i & ~s2_reg & s3_reg;
  end

  // Registers
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt_reg    <= '0;
      s1_reg     <= 1'b0;
      s2_reg     <= 1'b0;
      s3_reg     <= 1'b0;
      os_tick_o  <= 1'b0;
      ext_rise_o <= 1'b0;
      ext_fall_o <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      s1_reg     <= ext_clk_i;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      os_tick_o  <= os_next;
      ext_rise_o <= rise_next;
      ext_fall_o <= fall_next;
    end
  end
endmodule
`default_nettype wire

// [logic/usdp_parity.sv]
// Parity of a nine-bit character masked to its configured size
`timescale 1ns/100ps
`default_nettype none
module usdp_parity (
  input  wire logic [8:0] data_i,
  input  wire logic [2:0] size_i,
  input  wire logic       odd_i,
  output logic            parity_o
);
  // Unused upper bits are masked before the reduction
  always_comb begin
    logic [8:0] m;
    m = 9'h000;
    unique case (size_i)
      usdp_pkg::CSZ_5: m = 9'h01F;
      usdp_pkg::CSZ_6: m = 9'h03F;
      usdp_pkg::CSZ_7: m = 9'h07F;
      usdp_pkg::CSZ_9: m = 9'h1FF;
      default:         m = 9'h0FF;
    endcase
    parity_o = (^(data_i & m)) ^ odd_i;
  end
endmodule
`default_nettype wire

// [test/usdp_core_checker.sv]
// Checker for the USART data path, bound to the top module ports
`timescale 1ns/100ps
`default_nettype none
module usdp_chk (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic tx_enable_bit_i,
  input  wire logic rx_enable_bit_i,
  input  wire logic buffer_empty_irq_en_i,
  input  wire logic tx_complete_irq_en_i,
  input  wire logic data_wr_i,
  input  wire logic data_rd_i,
  input  wire logic tx_done_clr_i,
  input  wire logic tx_done_ack_i,
  input  wire logic port_tx_i,
  input  wire logic txd_o,
  input  wire logic tx_active_o,
  input  wire logic rx_active_o,
  input  wire logic buffer_empty_flag_o,
  input  wire logic tx_complete_flag_o,
  input  wire logic rx_complete_flag_o,
  input  wire logic buffer_empty_irq_o,
  input  wire logic tx_complete_irq_o
);
  // ----------------------------------------------------------------
  // Properties, one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Enable and flag held over two edges, so a registered lag is allowed
  sequence s_be_on;
    buffer_empty_irq_en_i && buffer_empty_flag_o ##1
    buffer_empty_irq_en_i && buffer_empty_flag_o;
  endsequence
  sequence s_tc_on;
    tx_complete_irq_en_i && tx_complete_flag_o ##1
    tx_complete_irq_en_i && tx_complete_flag_o;
  endsequence
  property p_be_irq; s_be_on |-> buffer_empty_irq_o; endproperty
  property p_be_quiet;
    !buffer_empty_irq_en_i ##1 !buffer_empty_irq_en_i |-> !buffer_empty_irq_o;
  endproperty
  property p_tc_irq; s_tc_on |-> tx_complete_irq_o; endproperty
  property p_wr_full;
    tx_enable_bit_i && data_wr_i |=> !buffer_empty_flag_o;
  endproperty
  property p_rd_clr;
    data_rd_i && rx_complete_flag_o |=> !rx_complete_flag_o;
  endproperty
  property p_rx_off;
    !rx_enable_bit_i |=> !rx_complete_flag_o && !rx_active_o;
  endproperty
  property p_tx_hold;
    tx_active_o && !buffer_empty_flag_o |=> tx_active_o;
  endproperty
  property p_tc_set;
    $rose(tx_complete_flag_o) |-> buffer_empty_flag_o && txd_o;
  endproperty
  property p_tc_clr;
    tx_complete_flag_o && (tx_done_clr_i || tx_done_ack_i)
      |=> !tx_complete_flag_o;
  endproperty
  // Past reset term keeps the first edge after release out of it
  property p_port;
    !tx_active_o ##1 !tx_active_o && $stable(port_tx_i) && $past(nrst_i)
      |-> txd_o == port_tx_i;
  endproperty
  property p_reset;
    $rose(nrst_i) |-> txd_o && buffer_empty_flag_o && !tx_complete_flag_o
      && !rx_complete_flag_o;
  endproperty
  a_be_irq:   assert property (p_be_irq) else $error("empty irq low");
  a_be_quiet: assert property (p_be_quiet) else $error("empty irq high");
  a_tc_irq:   assert property (p_tc_irq) else $error("done irq low");
  a_wr_full:  assert property (p_wr_full) else $error("empty kept");
  a_rd_clr:   assert property (p_rd_clr) else $error("rx flag kept");
  a_rx_off:   assert property (p_rx_off) else $error("rx not off");
  a_tx_hold:  assert property (p_tx_hold) else $error("tx left pin");
  a_tc_set:   assert property (p_tc_set) else $error("done early");
  a_tc_clr:   assert property (p_tc_clr) else $error("done kept");
  a_port:     assert property (p_port) else $error("pin not port");
  a_reset:    assert property (p_reset) else $error("bad reset");
endmodule
bind usdp_core usdp_chk chk_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .tx_enable_bit_i(tx_enable_bit_i), .rx_enable_bit_i(rx_enable_bit_i),
  .buffer_empty_irq_en_i(buffer_empty_irq_en_i),
  .tx_complete_irq_en_i(tx_complete_irq_en_i), .data_wr_i(data_wr_i),
  .data_rd_i(data_rd_i), .tx_done_clr_i(tx_done_clr_i),
  .tx_done_ack_i(tx_done_ack_i), .port_tx_i(port_tx_i), .txd_o(txd_o),
  .tx_active_o(tx_active_o), .rx_active_o(rx_active_o),
  .buffer_empty_flag_o(buffer_empty_flag_o),
  .tx_complete_flag_o(tx_complete_flag_o),
  .rx_complete_flag_o(rx_complete_flag_o),
  .buffer_empty_irq_o(buffer_empty_irq_o),
  .tx_complete_irq_o(tx_complete_irq_o));
`default_nettype wire

// [test/usdp_remote.sv]
// Remote serial transceiver model on the line side
`timescale 1ns/100ps
`default_nettype none
module usdp_remote (
  input  wire logic        clk_i,
  input  wire logic        txd_i,
  input  wire logic        act_i,
  input  wire logic [7:0]  bit_clks_i,
  input  wire logic [3:0]  nbits_i,
  input  wire logic        par_en_i,
  output logic             rxd_o,
  output logic             got_o,
  output logic [10:0]      word_o
);
  // ----------------------------------------------------------------
  // Line decoder: word is data[8:0], parity[9], first stop[10]
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [10:0] w;
    got_o = 1'b0;
    word_o = '0;
    rxd_o = 1'b1;
    forever begin
      @(negedge txd_i iff act_i);
      w = '0;
      n = nbits_i + par_en_i;
      repeat (bit_clks_i / 2) @(posedge clk_i);
      // Mid-bit samples; data LSB first, parity, then stop
      for (int i = 0; i <= n; i++) begin
        repeat (bit_clks_i) @(posedge clk_i);
        if (i < nbits_i) w[i] = txd_i;
        else if (i < n) w[9] = txd_i;
        else w[10] = txd_i;
      end
      word_o <= w;
      got_o <= 1'b1;
      @(posedge clk_i);
      got_o <= 1'b0;
    end
  end
  // Frame sender; the line idles high between frames
  task automatic send(input logic [10:0] w, input int stops);
    rxd_o <= 1'b0;
    repeat (bit_clks_i) @(posedge clk_i);
    for (int i = 0; i < nbits_i + par_en_i; i++) begin
      rxd_o <= (i < nbits_i) ? w[i] : w[9];
      repeat (bit_clks_i) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (bit_clks_i * stops) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [test/usdp_core_tb_top.sv]
// Self-checking bench for the USART transmit and receive data path
`timescale 1ns/100ps
`default_nettype none
module usdp_core_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, nrst, dbl, two_stop, tx_en, rx_en, be_ie, tc_ie;
  logic        ninth, wr, rd, clr, ack, port_tx, got;
  logic        txd, rxd, tx_act, rx_act, be, tc, rxc, rx9, be_irq, tc_irq;
  logic [2:0]  size;
  logic [1:0]  pmode;
  logic [7:0]  wdata, rdata, bit_clks;
  logic [3:0]  nbits;
  logic [8:0]  d;
  logic [10:0] word, w;
  logic [10:0] exp_q[$];
  logic [2:0]  codes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int          err_total, num_checks;
  // Bit time is 16 oversample ticks of two clocks, half with double speed
  assign bit_clks = dbl ? 8'h10 : 8'h20;
  assign nbits = (size == usdp_pkg::CSZ_9) ? 4'h9 : 4'h5 + {2'h0, size[1:0]};
  usdp_core usdp_core_inst (.ref_clk_i(clk), .nrst_i(nrst),
    .baud_div_i(12'h001), .double_speed_bit_i(dbl), .sync_mode_i(1'b0),
    .sample_rise_i(1'b0), .char_size_field_i(size), .parity_mode_i(pmode),
    .two_stop_i(two_stop), .tx_enable_bit_i(tx_en), .rx_enable_bit_i(rx_en),
    .buffer_empty_irq_en_i(be_ie), .tx_complete_irq_en_i(tc_ie),
    .tx_ninth_bit_i(ninth), .data_wr_i(wr), .data_wdata_i(wdata),
    .data_rd_i(rd), .tx_done_clr_i(clr), .tx_done_ack_i(ack),
    .ext_serial_clock_i(1'b0), .rxd_pin_i(rxd), .port_tx_i(port_tx),
    .txd_o(txd), .tx_active_o(tx_act), .rx_active_o(rx_act),
    .buffer_empty_flag_o(be), .tx_complete_flag_o(tc),
    .rx_complete_flag_o(rxc), .data_rdata_o(rdata), .rx_ninth_bit_o(rx9),
    .buffer_empty_irq_o(be_irq), .tx_complete_irq_o(tc_irq));
  usdp_remote usdp_remote_inst (.clk_i(clk), .txd_i(txd), .act_i(tx_act),
    .bit_clks_i(bit_clks), .nbits_i(nbits), .par_en_i(pmode[1]),
    .rxd_o(rxd), .got_o(got), .word_o(word));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected frame: masked data, parity as xor of data bits, inverted for odd and zero when off, high stop
  function automatic logic [10:0] frm(input logic [8:0] v);
    logic [8:0] m;
    m = v & ~(9'h1FF << nbits);
    return {1'b1, pmode[1] & (^m ^ pmode[0]), m};
  endfunction
  task automatic chk(input string nm, input logic [10:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Ninth bit travels with the low byte write
  task automatic put(input logic [8:0] v);
    @(posedge clk);
    wdata <= v[7:0];
    ninth <= v[8];
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic sel);
    @(posedge clk);
    if (sel) ack <= 1'b1;
    else clr <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    clr <= 1'b0;
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and frame monitor
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    tick(60000);
    err_total++;
    end_sim;
  end
  // Every decoded frame takes the oldest expectation
  initial begin
    forever begin
      @(posedge clk);
      if (got === 1'b1 && exp_q.size() == 0) chk("extra", 1, 0);
      else if (got === 1'b1) chk("frame", word, exp_q.pop_front());
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h19A0));
    {nrst, dbl, two_stop, tx_en, rx_en, be_ie, tc_ie} = '0;
    {ninth, wr, rd, clr, ack, wdata, pmode} = '0;
    port_tx = 1'b1;
    size = usdp_pkg::CSZ_8;
    tick(10);
    nrst <= 1'b1;
    tick(1);
    #1;
    chk("txd", txd, 1);
    chk("empty", be, 1);
    chk("done", tc, 0);
    tick(1);
    port_tx <= 1'b0;
    tick(3);
    #1;
    chk("port", txd, 0);
    tick(1);
    port_tx <= 1'b1;
    tx_en <= 1'b1;
    rx_en <= 1'b1;
    // Every size and random parity, two frames back to back
    foreach (codes[k]) begin
      tick(1);
      size <= codes[k];
      dbl <= k[0];
      pmode <= 2'($urandom);
      tick(1);
      for (int j = 0; j < 2; j++) begin
        d = 9'($urandom);
        for (int t = 0; t < 800 && be !== 1'b1; t++) tick(1);
        exp_q.push_back(frm(d));
        put(d);
        chk("empty", be, 0);
      end
      for (int t = 0; t < 2000 && !(tc === 1'b1 && exp_q.size() == 0); t++)
        tick(1);
      #1;
      chk("done", tc, 1);
      tick(1);
      tc_ie <= 1'b1;
      be_ie <= 1'b1;
      tick(3);
      #1;
      chk("tc_irq", tc_irq, 1);
      chk("be_irq", be_irq, 1);
      pulse(k[0]);
      chk("done", tc, 0);
      tick(1);
      tc_ie <= 1'b0;
      be_ie <= 1'b0;
    end
    // Receive every size, one or two stop bits, then read out
    foreach (codes[k]) begin
      tick(1);
      size <= codes[k];
      dbl <= k[0];
      two_stop <= ~k[0];
      pmode <= 2'($urandom);
      tick(1);
      w = frm(9'($urandom));
      usdp_remote_inst.send(w, 32'(two_stop) + 1);
      #1;
      chk("rx_flag", rxc, 1);
      chk("rx_data", rdata, w[7:0]);
      chk("rx_ninth", rx9, w[8]);
      tick(1);
      rd <= 1'b1;
      tick(1);
      rd <= 1'b0;
      #1;
      chk("rx_flag", rxc, 0);
    end
    // Disabling the receiver flushes unread data
    usdp_remote_inst.send(w, 1);
    rx_en <= 1'b0;
    tick(2);
    #1;
    chk("rx_flush", rxc, 0);
    chk("rx_owner", rx_act, 0);
    // Transmit disable waits for shifter and buffer to drain
    for (int j = 0; j < 2; j++) begin
      d = 9'($urandom);
      for (int t = 0; t < 800 && be !== 1'b1; t++) tick(1);
      exp_q.push_back(frm(d));
      put(d);
    end
    tick(1);
    tx_en <= 1'b0;
    tick(20);
    #1;
    chk("owner", tx_act, 1);
    for (int t = 0; t < 2000 && tx_act !== 1'b0; t++) tick(1);
    #1;
    chk("drained", exp_q.size(), 0);
    chk("pin", txd, port_tx);
    put(9'h0A5);
    tick(600);
    end_sim;
  end
endmodule
`default_nettype wire
